//--- hdl/itp_pkg.sv
// constants and types shared by the two-wire target port
package itp_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int WDT_SHORT_MS = 1;
  localparam int WDT_LONG_MS = 50;
  localparam int MS_PER_S = 1000;
  localparam int WDT_SHORT_CYCLES = WDT_SHORT_MS * (CLK_HZ / MS_PER_S);
  localparam int WDT_LONG_CYCLES = WDT_LONG_MS * (CLK_HZ / MS_PER_S);
  localparam int WDT_CNT_W = 21;
  localparam logic [5:0] TARGET_ADDR_HI = 6'h34;
  localparam logic [7:0] NVCONF_ADDR = 8'h70;
  localparam logic [7:0] NVCONF_RESET = 8'h00;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam int NVCONF_SPI_EN_BIT = 0;
  localparam int NVCONF_WDT_SEL_BIT = 1;
  localparam int NVCONF_WDT_EN_BIT = 2;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK, ST_WAIT} itp_state_t;
  typedef enum logic [1:0] {KIND_ADDR, KIND_REG, KIND_DATA} itp_kind_t;
endpackage

//--- hdl/itp_wdt_if.sv
// watchdog hookup between the target port and its lock-up timer
`timescale 1ns/1ps
interface itp_wdt_if;
  logic enable;
  logic longSel;
  logic holding;
  logic activity;
  logic timeout;
  modport port (output enable, output longSel, output holding, output activity, input timeout);
  modport wdt (input enable, input longSel, input holding, input activity, output timeout);
endinterface

//--- hdl/itp_wdt.sv
// lock-up watchdog: times how long the port holds the data line without bus activity
`timescale 1ns/1ps
module itp_wdt #(
  parameter int SHORT_CYCLES = itp_pkg::WDT_SHORT_CYCLES,
  parameter int LONG_CYCLES = itp_pkg::WDT_LONG_CYCLES
) (
  input wire logic clk_sys,
  input wire logic resetn,
  itp_wdt_if.wdt wd
);
  localparam logic [itp_pkg::WDT_CNT_W-1:0] SHORT_LIMIT = itp_pkg::WDT_CNT_W'(SHORT_CYCLES - 1);
  localparam logic [itp_pkg::WDT_CNT_W-1:0] LONG_LIMIT = itp_pkg::WDT_CNT_W'(LONG_CYCLES - 1);
  logic [itp_pkg::WDT_CNT_W-1:0] cnt_reg;
  logic [itp_pkg::WDT_CNT_W-1:0] cnt_next;
  logic timeout_reg;
  wire logic [itp_pkg::WDT_CNT_W-1:0] limit = wd.longSel ? LONG_LIMIT : SHORT_LIMIT;
  wire logic armed = wd.enable & wd.holding & ~wd.activity;
  wire logic expired = armed & (cnt_reg == limit);
  assign cnt_next = (armed & ~expired) ? cnt_reg + 1'b1 : '0;
  assign wd.timeout = timeout_reg;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cnt_reg <= '0;
      timeout_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      timeout_reg <= expired;
    end
  end
endmodule

//--- hdl/imu_i2c_target_port.sv
// two-wire target port: address match, register pointer, byte transfers, protocol select
`timescale 1ns/1ps
module imu_i2c_target_port #(
  parameter int WDT_SHORT_CYCLES = itp_pkg::WDT_SHORT_CYCLES,
  parameter int WDT_LONG_CYCLES = itp_pkg::WDT_LONG_CYCLES
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic primary_serial_clock_pin,
  input wire logic primary_serial_data_pin_in,
  output logic primary_serial_data_pin_out,
  output logic primary_serial_data_pin_oe,
  input wire logic address_select_pin,
  input wire logic chip_select_pin,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrStrobe,
  input wire logic [7:0] regRdData,
  output logic [7:0] nonvolatile_interface_config,
  output logic spiModeActive
);
  itp_wdt_if wd ();
  itp_wdt #(.SHORT_CYCLES(WDT_SHORT_CYCLES), .LONG_CYCLES(WDT_LONG_CYCLES)) u_wdt (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .wd(wd)
  );

  // pin synchronisers; the third stage only serves edge detection
  logic sclMeta_reg, sclSync_reg, sclPrev_reg;
  logic sdaMeta_reg, sdaSync_reg, sdaPrev_reg;
  logic selMeta_reg, selSync_reg;
  logic csMeta_reg, csSync_reg, csPrev_reg;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      {sclMeta_reg, sclSync_reg, sclPrev_reg} <= 3'h7;
      {sdaMeta_reg, sdaSync_reg, sdaPrev_reg} <= 3'h7;
      {selMeta_reg, selSync_reg} <= 2'h0;
      {csMeta_reg, csSync_reg, csPrev_reg} <= 3'h7;
    end else begin
      {sclMeta_reg, sclSync_reg, sclPrev_reg} <= {primary_serial_clock_pin, sclMeta_reg, sclSync_reg};
      {sdaMeta_reg, sdaSync_reg, sdaPrev_reg} <= {primary_serial_data_pin_in, sdaMeta_reg, sdaSync_reg};
      {selMeta_reg, selSync_reg} <= {address_select_pin, selMeta_reg};
      {csMeta_reg, csSync_reg, csPrev_reg} <= {chip_select_pin, csMeta_reg, csSync_reg};
    end
  end

  // edges are found by oversampling, so any bus speed up to 1 MHz fits 25 MHz sampling
  wire logic sclRise = sclSync_reg & ~sclPrev_reg;
  wire logic sclFall = ~sclSync_reg & sclPrev_reg;
  wire logic startSeen = sclSync_reg & sclPrev_reg & sdaPrev_reg & ~sdaSync_reg;
  wire logic stopSeen = sclSync_reg & sclPrev_reg & ~sdaPrev_reg & sdaSync_reg;
  wire logic csRise = csSync_reg & ~csPrev_reg;

  itp_pkg::itp_state_t state_reg, state_next;
  itp_pkg::itp_kind_t kind_reg, kind_next;
  logic [7:0] shift_reg, shift_next;
  logic [3:0] bitCnt_reg, bitCnt_next;
  logic [7:0] ptr_reg, ptr_next;
  logic [7:0] rdStart_reg, rdStart_next;
  logic [7:0] nvConf_reg, nvConf_next;
  logic [7:0] wrData_reg, wrData_next;
  logic wrStrobe_reg, wrStrobe_next;
  logic oe_reg, oe_next;
  logic rw_reg, rw_next;
  logic sawScl_reg, sawScl_next;
  logic spiSeen_reg;

  wire logic [6:0] targetAddr = {itp_pkg::TARGET_ADDR_HI, selSync_reg};
  wire logic addrMatch = (shift_reg[7:1] == targetAddr);
  wire logic ptrIsNv = (ptr_reg == itp_pkg::NVCONF_ADDR);
  wire logic [7:0] rdByte = ptrIsNv ? nvConf_reg : regRdData;
  // a pending acknowledge is finished first, so the write that sets the spi bit is still answered
  wire logic spiActive = (spiSeen_reg | nvConf_reg[itp_pkg::NVCONF_SPI_EN_BIT]) & ~oe_reg;

  assign wd.enable = nvConf_reg[itp_pkg::NVCONF_WDT_EN_BIT];
  assign wd.longSel = nvConf_reg[itp_pkg::NVCONF_WDT_SEL_BIT];
  assign wd.holding = oe_reg;
  assign wd.activity = sclRise | sclFall;

  always_comb begin
    state_next = state_reg;
    kind_next = kind_reg;
    shift_next = shift_reg;
    bitCnt_next = bitCnt_reg;
    ptr_next = ptr_reg;
    rdStart_next = rdStart_reg;
    nvConf_next = nvConf_reg;
    wrData_next = wrData_reg;
    wrStrobe_next = 1'b0;
    oe_next = oe_reg;
    rw_next = rw_reg;
    sawScl_next = sawScl_reg | sclFall;
    if (spiActive || wd.timeout) begin
      state_next = itp_pkg::ST_IDLE;
      oe_next = 1'b0;
    end else if (startSeen) begin
      state_next = itp_pkg::ST_RX;
      kind_next = itp_pkg::KIND_ADDR;
      bitCnt_next = '0;
      oe_next = 1'b0;
      sawScl_next = 1'b0;
    end else if (stopSeen && sawScl_reg) begin
      state_next = itp_pkg::ST_IDLE;
      oe_next = 1'b0;
    end else begin
      case (state_reg)
        itp_pkg::ST_RX: begin
          if (sclRise) begin
            shift_next = {shift_reg[6:0], sdaSync_reg};
            bitCnt_next = bitCnt_reg + 1'b1;
          end else if (sclFall && bitCnt_reg == itp_pkg::BITS_PER_BYTE) begin
            state_next = itp_pkg::ST_ACK;
            oe_next = 1'b1;
            case (kind_reg)
              itp_pkg::KIND_ADDR: begin
                rw_next = shift_reg[0];
                if (!addrMatch) begin
                  state_next = itp_pkg::ST_WAIT;
                  oe_next = 1'b0;
                end else if (shift_reg[0]) begin
                  ptr_next = rdStart_reg;
                end
              end
              itp_pkg::KIND_REG: begin
                ptr_next = shift_reg;
                rdStart_next = shift_reg;
              end
              default: begin
                wrData_next = shift_reg;
                wrStrobe_next = ~ptrIsNv;
                if (ptrIsNv) begin
                  nvConf_next = shift_reg;
                end
              end
            endcase
          end
        end
        itp_pkg::ST_ACK: begin
          if (sclFall) begin
            bitCnt_next = '0;
            if (kind_reg == itp_pkg::KIND_ADDR && rw_reg) begin
              state_next = itp_pkg::ST_TX;
              shift_next = rdByte;
              oe_next = ~rdByte[7];
            end else begin
              state_next = itp_pkg::ST_RX;
              oe_next = 1'b0;
              if (kind_reg == itp_pkg::KIND_ADDR) begin
                kind_next = itp_pkg::KIND_REG;
              end else if (kind_reg == itp_pkg::KIND_REG) begin
                kind_next = itp_pkg::KIND_DATA;
              end else begin
                ptr_next = ptr_reg + 1'b1;
              end
            end
          end
        end
        itp_pkg::ST_TX: begin
          if (sclFall) begin
            if (bitCnt_reg == itp_pkg::LAST_TX_BIT) begin
              state_next = itp_pkg::ST_MACK;
              oe_next = 1'b0;
            end else begin
              bitCnt_next = bitCnt_reg + 1'b1;
              shift_next = {shift_reg[6:0], 1'b0};
              oe_next = ~shift_reg[6];
            end
          end
        end
        itp_pkg::ST_MACK: begin
          if (sclRise) begin
            if (!sdaSync_reg) begin
              ptr_next = ptr_reg + 1'b1;
              state_next = itp_pkg::ST_ACK;
            end else begin
              state_next = itp_pkg::ST_WAIT;
            end
          end
        end
        itp_pkg::ST_IDLE, itp_pkg::ST_WAIT: begin
          oe_next = 1'b0;
        end
        default: begin
          state_next = itp_pkg::ST_IDLE;
          oe_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_reg <= itp_pkg::ST_IDLE;
      kind_reg <= itp_pkg::KIND_ADDR;
      shift_reg <= '0;
      bitCnt_reg <= '0;
      ptr_reg <= itp_pkg::PTR_RESET;
      rdStart_reg <= itp_pkg::PTR_RESET;
      nvConf_reg <= itp_pkg::NVCONF_RESET;
      wrData_reg <= '0;
      wrStrobe_reg <= 1'b0;
      oe_reg <= 1'b0;
      rw_reg <= 1'b0;
      sawScl_reg <= 1'b0;
      spiSeen_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      shift_reg <= shift_next;
      bitCnt_reg <= bitCnt_next;
      ptr_reg <= ptr_next;
      rdStart_reg <= rdStart_next;
      nvConf_reg <= nvConf_next;
      wrData_reg <= wrData_next;
      wrStrobe_reg <= wrStrobe_next;
      oe_reg <= oe_next;
      rw_reg <= rw_next;
      sawScl_reg <= sawScl_next;
      spiSeen_reg <= spiSeen_reg | csRise;
    end
  end

  // only the low level is ever driven; the clock line has no output at all
  assign primary_serial_data_pin_out = 1'b0;
  assign primary_serial_data_pin_oe = oe_reg;
  assign regAddr = ptr_reg;
  assign regWrData = wrData_reg;
  assign regWrStrobe = wrStrobe_reg;
  assign nonvolatile_interface_config = nvConf_reg;
  assign spiModeActive = spiActive;
endmodule

//--- verif/itp_port_assertions.sv
// assertion checker bound to the two-wire target port
`timescale 1ns/1ps
module itp_port_chk #(
  parameter int WDT_SHORT_CYCLES = 40,
  parameter int WDT_LONG_CYCLES = 200
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic primary_serial_clock_pin,
  input wire logic primary_serial_data_pin_out,
  input wire logic primary_serial_data_pin_oe,
  input wire logic [7:0] regAddr,
  input wire logic regWrStrobe,
  input wire logic [7:0] nonvolatile_interface_config,
  input wire logic spiModeActive
);
  wire oe = primary_serial_data_pin_oe;
  wire scl = primary_serial_clock_pin;
  wire [7:0] cfg = nonvolatile_interface_config;
  logic sclPrev_reg;
  int holdCnt_reg;
  int wdtLimit;
  assign wdtLimit = (cfg[1] ? WDT_LONG_CYCLES : WDT_SHORT_CYCLES) + 8;
  // counts raw pin edges, so a few cycles of slack cover the port's synchroniser
  always_ff @(posedge clk_sys) begin
    sclPrev_reg <= scl;
    if (!resetn || !oe || sclPrev_reg != scl) begin
      holdCnt_reg <= 0;
    end else begin
      holdCnt_reg <= holdCnt_reg + 1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_drive_low_only: assert property (primary_serial_data_pin_out == 1'h0) else $error("data driven high");
  a_strobe_pulse: assert property (regWrStrobe |=> !regWrStrobe [*2]) else $error("long strobe");
  a_no_cfg_strobe: assert property (regWrStrobe |-> regAddr != 8'h70) else $error("config strobed");
  a_ack_in_low: assert property ($rose(oe) |-> !scl) else $error("pull while clock high");
  a_release_in_low: assert property ($fell(oe) |-> !scl) else $error("release while clock high");
  a_spi_quiet: assert property (spiModeActive |-> !oe) else $error("driven in spi mode");
  a_spi_sticky: assert property (spiModeActive |=> spiModeActive) else $error("spi mode lost");
  a_cfg_forces_spi: assert property (cfg[0] && !oe |-> spiModeActive) else $error("spi bit ignored");
  a_wdt_bound: assert property (cfg[2] |-> holdCnt_reg <= wdtLimit) else $error("watchdog late");
  a_ptr_reset: assert property ($rose(resetn) |-> regAddr == 8'h00) else $error("pointer not cleared");
  c_write: cover property (regWrStrobe);
  c_spi: cover property (spiModeActive);
  c_wdt: cover property (cfg[2] && $fell(oe) && !scl);
endmodule
bind imu_i2c_target_port itp_port_chk #(.WDT_SHORT_CYCLES(WDT_SHORT_CYCLES), .WDT_LONG_CYCLES(WDT_LONG_CYCLES))
  chk_u (.clk_sys, .resetn, .primary_serial_clock_pin, .primary_serial_data_pin_out, .primary_serial_data_pin_oe,
  .regAddr, .regWrStrobe, .nonvolatile_interface_config, .spiModeActive);

//--- verif/itp_ctrl_model.sv
// bus controller model: owns the clock line, pulls data low or lets go
`timescale 1ns/1ps
module itp_ctrl_model (
  input wire logic clk,
  input wire logic sdaWire,
  output logic sclOut,
  output logic sdaPull
);
  initial begin
    sclOut = 1'h1;
    sdaPull = 1'h0;
  end
  // quarter bit of 80 ns; lines move only at falling system edges
  task automatic step(input logic c, input logic p);
    repeat (2) @(negedge clk);
    sclOut = c;
    sdaPull = p;
  endtask
  // a start is always followed by clock pulses, never by a stop
  task automatic start();
    step(sclOut, 1'h0);
    step(1'h1, 1'h0);
    step(1'h1, 1'h1);
    step(1'h0, 1'h1);
  endtask
  task automatic bitx(input logic v, output logic smp);
    step(1'h0, ~v);
    step(1'h1, ~v);
    step(1'h1, ~v);
    smp = sdaWire;
    step(1'h0, ~v);
  endtask
  // line released during the ninth clock for the target's answer
  task automatic send(input logic [7:0] b, output logic ack);
    logic d;
    for (int i = 7; i >= 0; i--) bitx(b[i], d);
    bitx(1'h1, ack);
  endtask
  // low answer asks for more, high answer ends the read
  task automatic recv(input logic nack, output logic [7:0] b);
    logic d;
    for (int i = 7; i >= 0; i--) bitx(1'h1, b[i]);
    bitx(nack, d);
  endtask
  // 450 us idle, covers the suspend and low-power write gaps
  task automatic suspend_gap();
    repeat (11250) @(negedge clk);
  endtask
  // 2 us idle after each transfer
  task automatic stop();
    step(1'h0, 1'h1);
    step(1'h1, 1'h1);
    step(1'h1, 1'h0);
    repeat (50) @(negedge clk);
  endtask
endmodule

//--- verif/testbench.sv
// self-checking bench for the two-wire target port
`timescale 1ns/1ps
module testbench;
  logic clk_sys = 1'h0;
  logic resetn = 1'h0;
  logic sel = 1'h0;
  logic csPin = 1'h1;
  logic oe, strobe, spi, scl, pull, s, sda;
  logic [7:0] ptr, wrData, cfg, rd, lastWr, cfgExp;
  int error_cnt = 0;
  int checks_done = 0;
  int wrCnt = 0;
  always #20 clk_sys = ~clk_sys;
  assign sda = ~(pull | oe);
  itp_ctrl_model ctl (.clk(clk_sys), .sdaWire(sda), .sclOut(scl), .sdaPull(pull));
  imu_i2c_target_port #(.WDT_SHORT_CYCLES(40), .WDT_LONG_CYCLES(200)) dut_u (.clk_sys(clk_sys), .resetn(resetn),
    .primary_serial_clock_pin(scl), .primary_serial_data_pin_in(sda), .primary_serial_data_pin_out(),
    .primary_serial_data_pin_oe(oe), .address_select_pin(sel), .chip_select_pin(csPin), .regAddr(ptr),
    .regWrData(wrData), .regWrStrobe(strobe), .regRdData(ptr ^ 8'hA5), .nonvolatile_interface_config(cfg),
    .spiModeActive(spi));
  always @(posedge clk_sys) begin
    if (strobe === 1'h1) begin
      lastWr <= wrData;
      wrCnt <= wrCnt + 1;
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic rst();
    resetn = 1'h0;
    repeat (10) @(negedge clk_sys);
    resetn = 1'h1;
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] r, input logic [7:0] d);
    ctl.start();
    ctl.send(8'hD0, s);
    chk("addr ack", 8'h00, {7'h00, s});
    ctl.send(r, s);
    chk("reg ack", 8'h00, {7'h00, s});
    ctl.send(d, s);
    chk("data ack", 8'h00, {7'h00, s});
    ctl.stop();
  endtask
  task automatic probe(input logic [6:0] a, input logic e);
    ctl.start();
    ctl.send({a, 1'h0}, s);
    chk("probe ack", {7'h00, e}, {7'h00, s});
    ctl.stop();
  endtask
  // register 0x70 reads back the config, everything else the bench pattern
  task automatic rdb(input bit setPtr, input logic [7:0] r, input int n, input logic [7:0] first);
    ctl.start();
    if (setPtr) begin
      ctl.send(8'hD0, s);
      ctl.send(r, s);
      ctl.start();
    end
    ctl.send(8'hD1, s);
    chk("read ack", 8'h00, {7'h00, s});
    for (int i = 0; i < n; i++) begin
      ctl.recv(i == n - 1, rd);
      chk("read data", (first == 8'h70) ? cfgExp : (first + i[7:0]) ^ 8'hA5, rd);
    end
    ctl.stop();
  endtask
  task automatic wdt(input logic [7:0] c, input int w, input logic e);
    wr(8'h70, c);
    ctl.start();
    for (int i = 7; i >= 0; i--) ctl.bitx(i == 7 || i == 6 || i == 4, s);
    repeat (w) @(negedge clk_sys);
    chk("ack held", {7'h00, e}, {7'h00, oe});
    ctl.bitx(1'h1, s);
    ctl.stop();
  endtask
  initial begin
    repeat (100000) @(posedge clk_sys);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    rst();
    cfgExp = 8'h00;
    rdb(0, 8'h00, 2, 8'h00);
    wr(8'h10, 8'h3C);
    chk("written byte", 8'h3C, lastWr);
    rdb(1, 8'h20, 3, 8'h20);
    rdb(0, 8'h00, 1, 8'h20);
    $display("test transfers done");
    probe(7'h69, 1'h1);
    probe(7'h78, 1'h1);
    sel = 1'h1;
    probe(7'h69, 1'h0);
    probe(7'h68, 1'h1);
    sel = 1'h0;
    $display("test addressing done");
    cfgExp = 8'h06;
    wr(8'h70, cfgExp);
    ctl.suspend_gap();
    rdb(1, 8'h70, 1, 8'h70);
    chk("strobes", 8'h01, wrCnt[7:0]);
    wdt(8'h04, 60, 1'h0);
    wdt(8'h06, 60, 1'h1);
    wdt(8'h06, 260, 1'h0);
    wdt(8'h00, 300, 1'h1);
    $display("test watchdog done");
    wr(8'h70, 8'h01);
    chk("spi by config", 8'h01, {7'h00, spi});
    probe(7'h68, 1'h1);
    rst();
    chk("config reset", 8'h00, cfg);
    chk("spi after reset", 8'h00, {7'h00, spi});
    csPin = 1'h0;
    repeat (4) @(negedge clk_sys);
    csPin = 1'h1;
    repeat (6) @(negedge clk_sys);
    chk("spi by select", 8'h01, {7'h00, spi});
    probe(7'h68, 1'h1);
    $display("test protocol select done");
    report_and_stop();
  end
endmodule
